// [rtl/dmw_pkg.sv]
package dmw_pkg;
  // host i/o ports of the graphics controller and sequencer
  localparam logic [15:0] GC_INDEX_PORT  = 16'h03ce;
  localparam logic [15:0] GC_DATA_PORT   = 16'h03cf;
  localparam logic [15:0] SEQ_INDEX_PORT = 16'h03c4;
  localparam logic [15:0] SEQ_DATA_PORT  = 16'h03c5;

  // graphics controller indices
  localparam logic [7:0] IDX_SET_RESET      = 8'h00;
  localparam logic [7:0] IDX_EN_SET_RESET   = 8'h01;
  localparam logic [7:0] IDX_GRAPHICS_MODE  = 8'h05;
  localparam logic [7:0] IDX_MEM_MAP        = 8'h06;
  localparam logic [7:0] IDX_BANK_PRIMARY   = 8'h09;
  localparam logic [7:0] IDX_BANK_SECONDARY = 8'h0a;
  localparam logic [7:0] IDX_WRITE_EXT      = 8'h0b;
  localparam logic [7:0] IDX_BG_COLOUR1     = 8'h10;
  localparam logic [7:0] IDX_FG_COLOUR1     = 8'h11;
  // sequencer indices
  localparam logic [7:0] IDX_PLANE_MASK     = 8'h02;
  localparam logic [7:0] IDX_EXT_SEQ_MODE   = 8'h07;

  // write_mode_extensions field positions
  localparam int WX_DUAL       = 0;
  localparam int WX_SHIFT3     = 1;
  localparam int WX_EXT        = 2;
  localparam int WX_WIDE_LATCH = 3;
  localparam int WX_SHIFT4     = 4;
  localparam int WX_GRAN16     = 5;
  localparam logic [7:0] WX_WRITABLE = 8'h3f;

  // other field positions
  localparam int GM_WRITE_MODE_HI = 2;
  localparam int MM_SEL_LO        = 2;
  localparam logic [1:0] MM_SEL_64K = 2'h1;
  localparam int SEQ_PAGE_LO      = 4;

  // values after reset
  localparam logic [7:0] RST_BANK      = 8'h00;
  localparam logic [7:0] RST_WRITE_EXT = 8'h00;
  localparam logic [7:0] RST_REG       = 8'h00;

  // transfer and latch sizes, address shifts
  localparam logic [4:0] BYTES_NORMAL = 5'h04;
  localparam logic [4:0] BYTES_EXT    = 5'h08;
  localparam logic [4:0] BYTES_EXT16  = 5'h10;
  localparam logic [3:0] LATCH_NORMAL = 4'h4;
  localparam logic [3:0] LATCH_WIDE   = 4'h8;
  localparam logic [2:0] SHIFT_BY8    = 3'h3;
  localparam logic [2:0] SHIFT_SHIFT4_PIXEL_ADDRESSING   = 3'h4;
endpackage : dmw_pkg

// [rtl/dmw_cfg_if.sv]
`timescale 1ns/1ps
interface dmw_cfg_if;
  logic [7:0] bank_offset_primary;
  logic [7:0] bank_offset_secondary;
  logic [7:0] write_mode_extensions;
  logic [7:0] set_reset_reg;
  logic [7:0] enable_set_reset_reg;
  logic [7:0] graphics_mode_reg;
  logic [7:0] memory_map_select_reg;
  logic [7:0] plane_write_mask;
  logic [7:0] extended_sequencer_mode_reg;
  logic [7:0] background_colour_byte1;
  logic [7:0] foreground_colour_byte1;

  modport ctrl (
    output bank_offset_primary, bank_offset_secondary, write_mode_extensions,
    output set_reset_reg, enable_set_reset_reg, graphics_mode_reg,
    output memory_map_select_reg, plane_write_mask, extended_sequencer_mode_reg,
    output background_colour_byte1, foreground_colour_byte1
  );
  modport map (
    input bank_offset_primary, bank_offset_secondary, write_mode_extensions,
    input memory_map_select_reg
  );
  modport wctl (
    input write_mode_extensions, set_reset_reg, enable_set_reset_reg,
    input graphics_mode_reg, plane_write_mask, extended_sequencer_mode_reg,
    input background_colour_byte1, foreground_colour_byte1
  );
endinterface : dmw_cfg_if

// [rtl/dmw_addr_map.sv]
`timescale 1ns/1ps
module dmw_addr_map (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration
  dmw_cfg_if.map           cfg,
  // host memory cycle
  input  wire logic        mem_req,
  input  wire logic [19:0] host_address,
  input  wire logic        linear_en,
  input  wire logic [4:0]  linear_address_hi,
  // translated address
  output logic             mem_valid,
  output logic [21:0]      mem_address
);
  typedef struct packed {
    logic        valid;
    logic [21:0] addr;
  } dmw_map_s;

  dmw_map_s state_ff;
  dmw_map_s nxt_state;

  logic        dual;
  logic        gran16;
  logic        map64;
  logic        ia16;
  logic        ia15;
  logic [7:0]  offset;
  logic [9:0]  memory_address_sum;
  logic [21:0] mapped;

  always_comb begin
    dual   = cfg.write_mode_extensions[dmw_pkg::WX_DUAL];
    gran16 = cfg.write_mode_extensions[dmw_pkg::WX_GRAN16];
    map64  = cfg.memory_map_select_reg[dmw_pkg::MM_SEL_LO +: 2] == dmw_pkg::MM_SEL_64K;
    // second offset only in dual window with host bit 15 high
    offset = (dual && host_address[15]) ? cfg.bank_offset_secondary
                                        : cfg.bank_offset_primary;
    ia16 = (map64 || dual) ? 1'b0 : host_address[16];
    ia15 = dual ? 1'b0 : host_address[15];
    // plain unsigned sums, cut to width, before any wrap control
    if (linear_en) begin
      memory_address_sum = {linear_address_hi, host_address[16:12]}
                         + {offset, 2'b00};
    end else if (gran16) begin
      memory_address_sum = {5'b00000, ia16, ia15, host_address[14:12]}
                         + {offset, 2'b00};
    end else begin
      memory_address_sum = {2'b00, 8'({3'b000, ia16, ia15, host_address[14:12]}
                         + offset)};
    end
    mapped = {memory_address_sum, host_address[11:0]};
    nxt_state.valid = mem_req;
    nxt_state.addr  = state_ff.addr;
    if (mem_req) begin
      if (cfg.write_mode_extensions[dmw_pkg::WX_EXT]
          && cfg.write_mode_extensions[dmw_pkg::WX_SHIFT4]) begin
        nxt_state.addr = mapped << dmw_pkg::SHIFT_SHIFT4_PIXEL_ADDRESSING;
      end else if (cfg.write_mode_extensions[dmw_pkg::WX_SHIFT3]) begin
        nxt_state.addr = mapped << dmw_pkg::SHIFT_BY8;
      end else begin
        nxt_state.addr = mapped;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign mem_valid   = state_ff.valid;
  assign mem_address = state_ff.addr;
endmodule : dmw_addr_map

// [rtl/dmw_write_ctl.sv]
`timescale 1ns/1ps
module dmw_write_ctl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration
  dmw_cfg_if.wctl          cfg,
  // derived write controls
  output logic [4:0]       bytes_per_transfer,
  output logic [3:0]       latch_bytes,
  output logic [15:0]      pixel_write_mask,
  output logic [7:0]       set_reset_eff,
  output logic [7:0]       enable_set_reset_eff,
  output logic [2:0]       write_mode,
  output logic             colour_ext_en,
  output logic [15:0]      colour_ext,
  output logic             page_select_lo,
  output logic             aperture_2mb
);
  typedef struct packed {
    logic [4:0]  bytes;
    logic [3:0]  latch;
    logic [15:0] mask;
    logic [7:0]  sr;
    logic [7:0]  esr;
    logic [2:0]  wmode;
    logic        cext;
    logic [15:0] colour;
    logic        page;
    logic        ap2;
  } dmw_wctl_s;

  dmw_wctl_s state_ff;
  dmw_wctl_s nxt_state;
  logic      ext;
  logic      ext16;

  always_comb begin
    ext   = cfg.write_mode_extensions[dmw_pkg::WX_EXT];
    // 16-bit enhanced bit counts only with extended writes on
    ext16 = ext && cfg.write_mode_extensions[dmw_pkg::WX_SHIFT4];
    nxt_state = state_ff;
    nxt_state.bytes = ext16 ? dmw_pkg::BYTES_EXT16
                    : ext ? dmw_pkg::BYTES_EXT : dmw_pkg::BYTES_NORMAL;
    nxt_state.latch = cfg.write_mode_extensions[dmw_pkg::WX_WIDE_LATCH]
                    ? dmw_pkg::LATCH_WIDE : dmw_pkg::LATCH_NORMAL;
    nxt_state.sr  = ext ? cfg.set_reset_reg : {4'h0, cfg.set_reset_reg[3:0]};
    nxt_state.esr = ext ? cfg.enable_set_reset_reg
                        : {4'h0, cfg.enable_set_reset_reg[3:0]};
    nxt_state.wmode = {ext && cfg.graphics_mode_reg[dmw_pkg::GM_WRITE_MODE_HI],
                       cfg.graphics_mode_reg[1:0]};
    for (int i = 0; i < 8; i++) begin
      // one mask bit covers both bytes of a pixel
      nxt_state.mask[2*i +: 2] = {2{cfg.plane_write_mask[i]}};
    end
    if (!ext16) begin
      nxt_state.mask = ext ? {8'h00, cfg.plane_write_mask}
                           : {12'h000, cfg.plane_write_mask[3:0]};
    end
    nxt_state.cext   = ext16;
    nxt_state.colour = ext16 ? {cfg.foreground_colour_byte1, cfg.background_colour_byte1}
                             : 16'h0000;
    nxt_state.page = cfg.write_mode_extensions[dmw_pkg::WX_GRAN16] ? 1'b0
                   : cfg.extended_sequencer_mode_reg[dmw_pkg::SEQ_PAGE_LO];
    nxt_state.ap2  = cfg.write_mode_extensions[dmw_pkg::WX_GRAN16];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bytes_per_transfer   = state_ff.bytes;
  assign latch_bytes          = state_ff.latch;
  assign pixel_write_mask     = state_ff.mask;
  assign set_reset_eff        = state_ff.sr;
  assign enable_set_reset_eff = state_ff.esr;
  assign write_mode           = state_ff.wmode;
  assign colour_ext_en        = state_ff.cext;
  assign colour_ext           = state_ff.colour;
  assign page_select_lo       = state_ff.page;
  assign aperture_2mb         = state_ff.ap2;
endmodule : dmw_write_ctl

// [rtl/dmw_mapper.sv]
`timescale 1ns/1ps
module dmw_mapper (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host i/o cycles
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  // host memory cycles
  input  wire logic        mem_req,
  input  wire logic [19:0] host_address,
  input  wire logic        linear_en,
  input  wire logic [4:0]  linear_address_hi,
  output logic             mem_valid,
  output logic [21:0]      mem_address,
  // write path controls
  output logic [4:0]       bytes_per_transfer,
  output logic [3:0]       latch_bytes,
  output logic [15:0]      pixel_write_mask,
  output logic [7:0]       set_reset_eff,
  output logic [7:0]       enable_set_reset_eff,
  output logic [2:0]       write_mode,
  output logic             colour_ext_en,
  output logic [15:0]      colour_ext,
  output logic             page_select_lo,
  output logic             aperture_2mb
);
  typedef struct packed {
    logic [7:0] gc_index;
    logic [7:0] seq_index;
    logic [7:0] bank_primary;
    logic [7:0] bank_secondary;
    logic [7:0] write_ext;
    logic [7:0] set_reset;
    logic [7:0] en_set_reset;
    logic [7:0] gmode;
    logic [7:0] map_select;
    logic [7:0] plane_mask;
    logic [7:0] seq_mode;
    logic [7:0] bg_colour;
    logic [7:0] fg_colour;
    logic [7:0] rdata;
  } dmw_regs_s;

  dmw_regs_s state_ff;
  dmw_regs_s nxt_state;

  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    port_hit = addr == port;
  endfunction : port_hit

  always_comb begin
    nxt_state = state_ff;
    if (io_wr) begin
      if (port_hit(io_addr, dmw_pkg::GC_INDEX_PORT)) begin
        nxt_state.gc_index = io_wdata;
      end
      if (port_hit(io_addr, dmw_pkg::SEQ_INDEX_PORT)) begin
        nxt_state.seq_index = io_wdata;
      end
      if (port_hit(io_addr, dmw_pkg::GC_DATA_PORT)) begin
        case (state_ff.gc_index)
          dmw_pkg::IDX_SET_RESET:      nxt_state.set_reset = io_wdata;
          dmw_pkg::IDX_EN_SET_RESET:   nxt_state.en_set_reset = io_wdata;
          dmw_pkg::IDX_GRAPHICS_MODE:  nxt_state.gmode = io_wdata;
          dmw_pkg::IDX_MEM_MAP:        nxt_state.map_select = io_wdata;
          dmw_pkg::IDX_BANK_PRIMARY:   nxt_state.bank_primary = io_wdata;
          dmw_pkg::IDX_BANK_SECONDARY: nxt_state.bank_secondary = io_wdata;
          dmw_pkg::IDX_WRITE_EXT: begin
            nxt_state.write_ext = io_wdata & dmw_pkg::WX_WRITABLE;
            // turning extended writes off drops the widened upper nibbles
            if (state_ff.write_ext[dmw_pkg::WX_EXT] && !io_wdata[dmw_pkg::WX_EXT]) begin
              nxt_state.set_reset[7:4]    = 4'h0;
              nxt_state.en_set_reset[7:4] = 4'h0;
            end
          end
          dmw_pkg::IDX_BG_COLOUR1:     nxt_state.bg_colour = io_wdata;
          dmw_pkg::IDX_FG_COLOUR1:     nxt_state.fg_colour = io_wdata;
          default: ;
        endcase
      end
      if (port_hit(io_addr, dmw_pkg::SEQ_DATA_PORT)) begin
        case (state_ff.seq_index)
          dmw_pkg::IDX_PLANE_MASK:   nxt_state.plane_mask = io_wdata;
          dmw_pkg::IDX_EXT_SEQ_MODE: nxt_state.seq_mode = io_wdata;
          default: ;
        endcase
      end
    end
    // read data is registered; unknown ports and indices read zero
    nxt_state.rdata = 8'h00;
    if (io_rd) begin
      if (port_hit(io_addr, dmw_pkg::GC_INDEX_PORT)) begin
        nxt_state.rdata = state_ff.gc_index;
      end else if (port_hit(io_addr, dmw_pkg::SEQ_INDEX_PORT)) begin
        nxt_state.rdata = state_ff.seq_index;
      end else if (port_hit(io_addr, dmw_pkg::GC_DATA_PORT)) begin
        case (state_ff.gc_index)
          dmw_pkg::IDX_SET_RESET:      nxt_state.rdata = state_ff.set_reset;
          dmw_pkg::IDX_EN_SET_RESET:   nxt_state.rdata = state_ff.en_set_reset;
          dmw_pkg::IDX_GRAPHICS_MODE:  nxt_state.rdata = state_ff.gmode;
          dmw_pkg::IDX_MEM_MAP:        nxt_state.rdata = state_ff.map_select;
          dmw_pkg::IDX_BANK_PRIMARY:   nxt_state.rdata = state_ff.bank_primary;
          dmw_pkg::IDX_BANK_SECONDARY: nxt_state.rdata = state_ff.bank_secondary;
          dmw_pkg::IDX_WRITE_EXT:      nxt_state.rdata = state_ff.write_ext;
          dmw_pkg::IDX_BG_COLOUR1:     nxt_state.rdata = state_ff.bg_colour;
          dmw_pkg::IDX_FG_COLOUR1:     nxt_state.rdata = state_ff.fg_colour;
          default:                     nxt_state.rdata = 8'h00;
        endcase
      end else if (port_hit(io_addr, dmw_pkg::SEQ_DATA_PORT)) begin
        case (state_ff.seq_index)
          dmw_pkg::IDX_PLANE_MASK:   nxt_state.rdata = state_ff.plane_mask;
          dmw_pkg::IDX_EXT_SEQ_MODE: nxt_state.rdata = state_ff.seq_mode;
          default:                   nxt_state.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff                <= '0;
      state_ff.bank_primary   <= dmw_pkg::RST_BANK;
      state_ff.bank_secondary <= dmw_pkg::RST_BANK;
      state_ff.write_ext      <= dmw_pkg::RST_WRITE_EXT;
      state_ff.plane_mask     <= dmw_pkg::RST_REG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign io_rdata = state_ff.rdata;

  dmw_cfg_if cfg ();

  assign cfg.bank_offset_primary         = state_ff.bank_primary;
  assign cfg.bank_offset_secondary       = state_ff.bank_secondary;
  assign cfg.write_mode_extensions       = state_ff.write_ext;
  assign cfg.set_reset_reg               = state_ff.set_reset;
  assign cfg.enable_set_reset_reg        = state_ff.en_set_reset;
  assign cfg.graphics_mode_reg           = state_ff.gmode;
  assign cfg.memory_map_select_reg       = state_ff.map_select;
  assign cfg.plane_write_mask            = state_ff.plane_mask;
  assign cfg.extended_sequencer_mode_reg = state_ff.seq_mode;
  assign cfg.background_colour_byte1     = state_ff.bg_colour;
  assign cfg.foreground_colour_byte1     = state_ff.fg_colour;

  // software keeps by-8 and by-16 apart; if both are set, by-16 wins only with extended writes on, else by-8 wins
  dmw_addr_map u_map (
    .clk               (clk),
    .rst               (rst),
    .cfg               (cfg),
    .mem_req           (mem_req),
    .host_address      (host_address),
    .linear_en         (linear_en),
    .linear_address_hi (linear_address_hi),
    .mem_valid         (mem_valid),
    .mem_address       (mem_address)
  );

  dmw_write_ctl u_wctl (
    .clk                  (clk),
    .rst                  (rst),
    .cfg                  (cfg),
    .bytes_per_transfer   (bytes_per_transfer),
    .latch_bytes          (latch_bytes),
    .pixel_write_mask     (pixel_write_mask),
    .set_reset_eff        (set_reset_eff),
    .enable_set_reset_eff (enable_set_reset_eff),
    .write_mode           (write_mode),
    .colour_ext_en        (colour_ext_en),
    .colour_ext           (colour_ext),
    .page_select_lo       (page_select_lo),
    .aperture_2mb         (aperture_2mb)
  );
endmodule : dmw_mapper

// [sim/dmw_props.sv]
`timescale 1ns/1ps
module dmw_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // memory path
  input wire logic        mem_req,
  input wire logic        mem_valid,
  input wire logic [21:0] mem_address,
  // write controls
  input wire logic [4:0]  bytes_per_transfer,
  input wire logic [3:0]  latch_bytes,
  input wire logic [15:0] pixel_write_mask,
  input wire logic [7:0]  set_reset_eff,
  input wire logic [7:0]  enable_set_reset_eff,
  input wire logic [2:0]  write_mode,
  input wire logic        colour_ext_en,
  input wire logic [15:0] colour_ext,
  input wire logic        page_select_lo,
  input wire logic        aperture_2mb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_valid_follows: assert property (mem_req |=> mem_valid)
    else $error("translated address not flagged after request");
  a_valid_idle: assert property (!mem_req |=> !mem_valid)
    else $error("translated address flagged without request");
  a_addr_hold: assert property (!mem_req |=> $stable(mem_address))
    else $error("memory address moved without request");
  // derived outputs read zero in reset, so skip the first edge after it
  a_bytes_legal: assert property (!$past(rst) |-> bytes_per_transfer inside {5'h04, 5'h08, 5'h10})
    else $error("illegal transfer size");
  a_latch_legal: assert property (!$past(rst) |-> latch_bytes inside {4'h4, 4'h8})
    else $error("illegal latch width");
  a_colour_mode: assert property (!$past(rst) |-> colour_ext_en == (bytes_per_transfer == 5'h10))
    else $error("colour extension not tied to 16-byte mode");
  a_colour_off: assert property (!colour_ext_en |-> colour_ext == 16'h0000)
    else $error("colour extension leaks while disabled");
  a_mask_pairs: assert property (colour_ext_en |->
      ((pixel_write_mask >> 1) & 16'h5555) == (pixel_write_mask & 16'h5555))
    else $error("mask bit not doubled");
  a_narrow_regs: assert property (bytes_per_transfer == 5'h04 |-> {pixel_write_mask[15:4],
      set_reset_eff[7:4], enable_set_reset_eff[7:4], write_mode[2]} == 21'h0)
    else $error("upper bits visible outside extended writes");
  a_gran_page: assert property (aperture_2mb |-> !page_select_lo)
    else $error("page bit honoured at 16K granularity");
  a_shift_sixteen: assert property (mem_valid && bytes_per_transfer == 5'h10 |->
      mem_address[3:0] == 4'h0)
    else $error("address not shifted by four");

  c_enhanced_access: cover property (mem_valid && colour_ext_en);
  c_wide_aperture: cover property (aperture_2mb);
  c_wide_latch: cover property (latch_bytes == 4'h8);
endmodule : dmw_props

// [sim/dmw_host_model.sv]
`timescale 1ns/1ps
module dmw_host_model (
  // clock
  input  wire logic        clk,
  // i/o cycles
  output logic             io_wr,
  output logic             io_rd,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata,
  input  wire logic [7:0]  io_rdata,
  // memory cycles
  output logic             mem_req,
  output logic [19:0]      host_address,
  output logic             linear_en,
  output logic [4:0]       linear_address_hi,
  input  wire logic        mem_valid,
  input  wire logic [21:0] mem_address
);
  logic [7:0] wx_sh;

  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mem_req = 1'b0;
    host_address = 20'h00000;
    linear_en = 1'b0;
    linear_address_hi = 5'h00;
    wx_sh = 8'h00;
  end

  // no block transfers are issued; writing by-16 addressing clears the by-8 bit first, so the two are never set together
  task automatic reg_wr(input logic [15:0] ip, input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (ip == dmw_pkg::GC_INDEX_PORT && idx == dmw_pkg::IDX_WRITE_EXT) begin
      if (v[dmw_pkg::WX_SHIFT4]) v[dmw_pkg::WX_SHIFT3] = 1'b0;
      wx_sh = v;
    end
    @(posedge clk);
    #1;
    io_wr = 1'b1;
    io_addr = ip;
    io_wdata = idx;
    @(posedge clk);
    #1;
    io_addr = ip + 16'h0001;
    io_wdata = v;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~v;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] ip, input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_wr = 1'b1;
    io_addr = ip;
    io_wdata = idx;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b1;
    io_addr = ip + 16'h0001;
    io_wdata = ~idx;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
    io_addr = ~io_addr;
  endtask : reg_rd

  task automatic mem_cyc(input logic [19:0] a, input logic lin, input logic [4:0] la,
                         output logic [21:0] got, output logic vld);
    @(posedge clk);
    #1;
    mem_req = 1'b1;
    host_address = a;
    linear_en = lin & ~wx_sh[dmw_pkg::WX_DUAL];
    linear_address_hi = la;
    @(posedge clk);
    #1;
    mem_req = 1'b0;
    host_address = ~a;
    got = mem_address;
    vld = mem_valid;
  endtask : mem_cyc
endmodule : dmw_host_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0]  wx, off0, off1, mm;
    logic        lin;
    logic [4:0]  la;
    logic [19:0] a;
    logic [21:0] exp;
    logic [4:0]  bytes;
  } dmw_row_s;

  logic        clk, rst, io_wr, io_rd, mem_req, linear_en, mem_valid;
  logic        colour_ext_en, page_select_lo, aperture_2mb, vld;
  logic [15:0] io_addr, pixel_write_mask, colour_ext;
  logic [7:0]  io_wdata, io_rdata, set_reset_eff, enable_set_reset_eff, d;
  logic [19:0] host_address;
  logic [4:0]  linear_address_hi, bytes_per_transfer;
  logic [21:0] mem_address, got;
  logic [3:0]  latch_bytes;
  logic [2:0]  write_mode;
  int          err_total, num_checks;
  dmw_row_s rows [12] = '{
    '{8'h00, 8'h12, 8'h55, 8'h00, 1'b0, 5'h00, 20'h12345, 22'h024345, 5'h04},
    '{8'h01, 8'h10, 8'h30, 8'h00, 1'b0, 5'h00, 20'h09abc, 22'h031abc, 5'h04},
    '{8'h01, 8'h10, 8'h30, 8'h00, 1'b0, 5'h00, 20'h11234, 22'h011234, 5'h04},
    '{8'h00, 8'h10, 8'h55, 8'h04, 1'b0, 5'h00, 20'h19abc, 22'h019abc, 5'h04},
    '{8'h00, 8'h00, 8'h55, 8'h00, 1'b0, 5'h00, 20'h08000, 22'h008000, 5'h04},
    '{8'h20, 8'h81, 8'h55, 8'h00, 1'b0, 5'h00, 20'h13456, 22'h217456, 5'h04},
    '{8'h20, 8'hff, 8'h55, 8'h00, 1'b0, 5'h00, 20'h1f000, 22'h01b000, 5'h04},
    '{8'h00, 8'hf0, 8'h55, 8'h00, 1'b0, 5'h00, 20'h10000, 22'h000000, 5'h04},
    '{8'h00, 8'h01, 8'h55, 8'h00, 1'b1, 5'h15, 20'h12345, 22'h2b6345, 5'h04},
    '{8'h02, 8'h01, 8'h55, 8'h00, 1'b0, 5'h00, 20'h00011, 22'h008088, 5'h04},
    '{8'h14, 8'h00, 8'h55, 8'h00, 1'b0, 5'h00, 20'h00011, 22'h000110, 5'h10},
    '{8'h10, 8'h00, 8'h55, 8'h00, 1'b0, 5'h00, 20'h00011, 22'h000011, 5'h04}
  };

  dmw_mapper dmw_mapper_i (.clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req), .host_address(host_address),
    .linear_en(linear_en), .linear_address_hi(linear_address_hi), .mem_valid(mem_valid),
    .mem_address(mem_address), .bytes_per_transfer(bytes_per_transfer),
    .latch_bytes(latch_bytes), .pixel_write_mask(pixel_write_mask),
    .set_reset_eff(set_reset_eff), .enable_set_reset_eff(enable_set_reset_eff),
    .write_mode(write_mode), .colour_ext_en(colour_ext_en), .colour_ext(colour_ext),
    .page_select_lo(page_select_lo), .aperture_2mb(aperture_2mb));
  dmw_host_model dmw_host_model_i (.clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req), .host_address(host_address),
    .linear_en(linear_en), .linear_address_hi(linear_address_hi), .mem_valid(mem_valid),
    .mem_address(mem_address));

  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic gw(input logic [7:0] idx, input logic [7:0] v);
    dmw_host_model_i.reg_wr(dmw_pkg::GC_INDEX_PORT, idx, v);
  endtask : gw

  // derived outputs trail the registers by one cycle
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    tally_and_finish();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_BANK_PRIMARY, d);
    chk(d, dmw_pkg::RST_BANK);
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_BANK_SECONDARY, d);
    chk(d, dmw_pkg::RST_BANK);
    foreach (rows[i]) begin
      gw(dmw_pkg::IDX_WRITE_EXT, rows[i].wx);
      gw(dmw_pkg::IDX_BANK_PRIMARY, rows[i].off0);
      gw(dmw_pkg::IDX_BANK_SECONDARY, rows[i].off1);
      gw(dmw_pkg::IDX_MEM_MAP, rows[i].mm);
      dmw_host_model_i.mem_cyc(rows[i].a, rows[i].lin, rows[i].la, got, vld);
      chk(got, rows[i].exp);
      chk(vld, 1'b1);
      chk(bytes_per_transfer, rows[i].bytes);
    end
    dmw_host_model_i.reg_wr(dmw_pkg::SEQ_INDEX_PORT, dmw_pkg::IDX_PLANE_MASK, 8'ha5);
    gw(dmw_pkg::IDX_SET_RESET, 8'hf3);
    gw(dmw_pkg::IDX_EN_SET_RESET, 8'he1);
    gw(dmw_pkg::IDX_GRAPHICS_MODE, 8'h07);
    gw(dmw_pkg::IDX_BG_COLOUR1, 8'h12);
    gw(dmw_pkg::IDX_FG_COLOUR1, 8'h34);
    gw(dmw_pkg::IDX_WRITE_EXT, 8'h0c);
    settle();
    chk({set_reset_eff, enable_set_reset_eff, write_mode}, {8'hf3, 8'he1, 3'h7});
    chk(pixel_write_mask, 16'h00a5);
    chk({bytes_per_transfer, latch_bytes}, {5'h08, 4'h8});
    gw(dmw_pkg::IDX_WRITE_EXT, 8'h14);
    settle();
    chk(pixel_write_mask, 16'hcc33);
    chk({colour_ext_en, colour_ext}, {1'b1, 16'h3412});
    chk({bytes_per_transfer, latch_bytes}, {5'h10, 4'h4});
    gw(dmw_pkg::IDX_WRITE_EXT, 8'h00);
    settle();
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_SET_RESET, d);
    chk(d, 8'h03);
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_EN_SET_RESET, d);
    chk(d, 8'h01);
    chk({pixel_write_mask, write_mode, colour_ext_en}, {16'h0005, 3'h3, 1'b0});
    dmw_host_model_i.reg_wr(dmw_pkg::SEQ_INDEX_PORT, dmw_pkg::IDX_EXT_SEQ_MODE, 8'h10);
    settle();
    chk({page_select_lo, aperture_2mb}, 2'b10);
    gw(dmw_pkg::IDX_WRITE_EXT, 8'h20);
    settle();
    chk({page_select_lo, aperture_2mb}, 2'b01);
    gw(dmw_pkg::IDX_WRITE_EXT, 8'hef);
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_WRITE_EXT, d);
    chk(d, 8'h2f);
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, 8'h0c, d);
    chk(d, 8'h00);
    // reset in mid-run with both offsets non-zero and extensions on
    gw(dmw_pkg::IDX_BANK_PRIMARY, 8'h5a);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    settle();
    chk({bytes_per_transfer, latch_bytes, aperture_2mb}, {5'h04, 4'h4, 1'b0});
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_BANK_PRIMARY, d);
    chk(d, dmw_pkg::RST_BANK);
    dmw_host_model_i.reg_rd(dmw_pkg::GC_INDEX_PORT, dmw_pkg::IDX_BANK_SECONDARY, d);
    chk(d, dmw_pkg::RST_BANK);
    tally_and_finish();
  end
endmodule : tb

bind dmw_mapper dmw_props dmw_props_i (.clk(clk), .rst(rst), .mem_req(mem_req),
  .mem_valid(mem_valid), .mem_address(mem_address), .bytes_per_transfer(bytes_per_transfer),
  .latch_bytes(latch_bytes), .pixel_write_mask(pixel_write_mask),
  .set_reset_eff(set_reset_eff), .enable_set_reset_eff(enable_set_reset_eff),
  .write_mode(write_mode), .colour_ext_en(colour_ext_en), .colour_ext(colour_ext),
  .page_select_lo(page_select_lo), .aperture_2mb(aperture_2mb));
